// file: verilog/timer_irq_dma_control.sv
module timer_irq_dma_control (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Timer datapath events, one-cycle pulses
    input  wire logic        capture0_evt,
    input  wire logic        capture1_evt,
    input  wire logic        compare0_evt,
    input  wire logic        compare1_evt,
    input  wire logic        wrap_evt,
    // End of block from the DMA engine, one-cycle pulses
    input  wire logic        capture0_eob,
    input  wire logic        compare0_eob,
    // Interrupt side
    output logic             irq_req,
    output logic [7:0]       irq_vector,
    // DMA side
    output logic             dma_req_capture0,
    output logic             dma_req_compare0,
    output logic [7:0]       dma_counter_ptr,
    output logic [7:0]       dma_address_ptr,
    output logic             dma_use_regfile,
    output logic             dma_use_seg_dma,
    output logic             dma_use_address_ptr,
    output logic             dma_table_select
);

    // ----------------------------------------------------------------
    // State.
    // ----------------------------------------------------------------
    logic [7:0]  irq_dma_mask;
    logic [7:0]  timer_flags;
    logic        swap_mode_enable;
    logic        capture_irq_combine;
    logic        capture0_end;
    logic        compare0_end;
    logic [5:0]  dma_counter_ptr_msbs;
    logic        dma_area_select;
    logic [5:0]  dma_address_ptr_msbs;
    logic        memory_extension_select;
    logic        dma_direction_bit;
    logic [4:0]  vector_msbs;
    logic [1:0]  vector_group;
    logic        aw_full;
    logic        w_full;
    logic [7:0]  wr_index;
    logic [7:0]  wr_byte;
    logic        wr_lane0;

    // ----------------------------------------------------------------
    // Bus write path.
    // ----------------------------------------------------------------
    // Address and data are latched separately, so either may come first.
    wire do_wr   = aw_full && w_full && !s_axi_bvalid;
    wire wr_en   = do_wr && wr_lane0;
    wire hit_cnt = wr_index == timer_irq_pkg::IDX_CNT_PTR;
    wire hit_adr = wr_index == timer_irq_pkg::IDX_ADR_PTR;
    wire hit_vec = wr_index == timer_irq_pkg::IDX_VECTOR;
    wire hit_flg = wr_index == timer_irq_pkg::IDX_FLAGS;
    wire hit_ctl = wr_index == timer_irq_pkg::IDX_CTRL;
    wire hit_msk = wr_index == timer_irq_pkg::IDX_MASK;
    wire wr_ok   = hit_cnt || hit_adr || hit_vec || hit_flg || hit_ctl || hit_msk;
    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready  = !w_full && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            wr_index     <= 8'h00;
            wr_byte      <= 8'h00;
            wr_lane0     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= timer_irq_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full  <= 1'b1;
                wr_index <= s_axi_awaddr[9:2];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full   <= 1'b1;
                wr_byte  <= s_axi_wdata[7:0];
                wr_lane0 <= s_axi_wstrb[0];
            end
            if (do_wr)
            begin
                aw_full      <= 1'b0;
                w_full       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? timer_irq_pkg::RESP_OKAY
                                      : timer_irq_pkg::RESP_ERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Event steering.
    // ----------------------------------------------------------------
    wire cp0_dma = irq_dma_mask[timer_irq_pkg::B_CAP0_DMA];
    wire cm0_dma = irq_dma_mask[timer_irq_pkg::B_CMP0_DMA];
    wire cap0_to_dma = capture0_evt && cp0_dma;
    wire cmp0_to_dma = compare0_evt && cm0_dma;
    wire cap0_done   = capture0_eob && cp0_dma;
    wire cmp0_done   = compare0_eob && cm0_dma;

    logic [7:0] flag_set;
    always_comb
    begin
        flag_set = 8'h00;
        flag_set[timer_irq_pkg::F_CP0]  = capture0_evt && !cp0_dma;
        flag_set[timer_irq_pkg::F_CP1]  = capture1_evt;
        flag_set[timer_irq_pkg::F_CM0]  = compare0_evt && !cm0_dma;
        flag_set[timer_irq_pkg::F_CM1]  = compare1_evt;
        flag_set[timer_irq_pkg::F_WRAP] = wrap_evt;
        flag_set[timer_irq_pkg::F_EOB0] = cap0_done;
        flag_set[timer_irq_pkg::F_EOB1] = cmp0_done;
    end
    // Writing a one clears a flag; a new event in that cycle wins.
    wire [7:0] flag_clr   = (wr_en && hit_flg) ? wr_byte : 8'h00;
    wire [7:0] next_flags = (timer_flags & ~flag_clr) | flag_set;
    wire [7:0] mask_wr    = (wr_en && hit_msk) ? wr_byte : irq_dma_mask;
    wire [7:0] dma_clr    = {1'b0, cap0_done, 2'b00, cmp0_done, 3'b000};
    wire [7:0] next_mask  = mask_wr & ~dma_clr;

    wire swap_now  = swap_mode_enable;
    wire [7:0] ctl_clr = (wr_en && hit_ctl) ? wr_byte : 8'h00;
    wire next_cpe  = (capture0_end && !ctl_clr[timer_irq_pkg::C_CPE])
                     || (cap0_done && swap_now);
    wire next_cme  = (compare0_end && !ctl_clr[timer_irq_pkg::C_CME])
                     || (cmp0_done && swap_now);
    wire cpe_view  = capture0_end || !swap_now;
    wire cme_view  = compare0_end || !swap_now;
    wire ptr_flip = cmp0_done && swap_now;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_dma_mask <= timer_irq_pkg::RST_MASK;
            timer_flags  <= timer_irq_pkg::RST_FLAGS;
            capture0_end <= 1'b0;
            compare0_end <= 1'b0;
        end
        else
        begin
            irq_dma_mask <= next_mask;
            timer_flags  <= next_flags;
            capture0_end <= next_cpe;
            compare0_end <= next_cme;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            swap_mode_enable    <= 1'b0;
            capture_irq_combine <= 1'b0;
            vector_msbs         <= timer_irq_pkg::RST_VEC;
        end
        else
        begin
            if (wr_en && hit_ctl)
            begin
                swap_mode_enable    <= wr_byte[timer_irq_pkg::C_SWAP];
                capture_irq_combine <= wr_byte[timer_irq_pkg::C_COMB];
            end
            if (wr_en && hit_vec)
                vector_msbs <= wr_byte[7:3];
        end
    end

    // ----------------------------------------------------------------
    // DMA pointers.
    // ----------------------------------------------------------------
    wire [5:0] cnt_wr = (wr_en && hit_cnt) ? wr_byte[7:2] : dma_counter_ptr_msbs;
    wire [5:0] adr_wr = (wr_en && hit_adr) ? wr_byte[7:2] : dma_address_ptr_msbs;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dma_counter_ptr_msbs    <= timer_irq_pkg::RST_PTR;
            dma_address_ptr_msbs    <= timer_irq_pkg::RST_PTR;
            dma_area_select         <= 1'b0;
            memory_extension_select <= 1'b0;
            dma_direction_bit       <= 1'b0;
            dma_req_capture0        <= 1'b0;
            dma_req_compare0        <= 1'b0;
        end
        else
        begin
            dma_counter_ptr_msbs <= cnt_wr ^ {5'h00, ptr_flip};
            dma_address_ptr_msbs <= adr_wr ^ {5'h00, ptr_flip};
            if (wr_en && hit_cnt)
                dma_area_select <= wr_byte[timer_irq_pkg::P_SEL];
            if (wr_en && hit_adr)
                memory_extension_select <= wr_byte[timer_irq_pkg::P_SEL];
            if (cmp0_to_dma)
                dma_direction_bit <= 1'b1;
            else if (cap0_to_dma)
                dma_direction_bit <= 1'b0;
            dma_req_capture0 <= cap0_to_dma;
            dma_req_compare0 <= cmp0_to_dma;
        end
    end

    assign dma_counter_ptr = {dma_counter_ptr_msbs, dma_direction_bit, dma_area_select};
    assign dma_address_ptr = {dma_address_ptr_msbs, dma_direction_bit,
                              memory_extension_select};
    assign dma_use_regfile = dma_area_select;
    assign dma_use_seg_dma = !dma_area_select && memory_extension_select;
    assign dma_use_address_ptr = !dma_area_select;
    assign dma_table_select    = dma_address_ptr_msbs[0];

    // ----------------------------------------------------------------
    // Interrupt request and vector.
    // ----------------------------------------------------------------
    wire gen   = irq_dma_mask[timer_irq_pkg::B_GLOBAL];
    // capture 0 or its end of block
    wire c0_on = irq_dma_mask[timer_irq_pkg::B_CAP0_IRQ]
                 && (timer_flags[timer_irq_pkg::F_CP0] || timer_flags[timer_irq_pkg::F_EOB0]);
    wire c1_on = irq_dma_mask[timer_irq_pkg::B_CAP1_IRQ] && timer_flags[timer_irq_pkg::F_CP1];
    // OR or AND of both captures
    wire cap_q = capture_irq_combine ? (c0_on && c1_on) : (c0_on || c1_on);
    wire cmp_q = (irq_dma_mask[timer_irq_pkg::B_CMP0_IRQ]
                  && (timer_flags[timer_irq_pkg::F_CM0] || timer_flags[timer_irq_pkg::F_EOB1]))
                 || (irq_dma_mask[timer_irq_pkg::B_CMP1_IRQ] && timer_flags[timer_irq_pkg::F_CM1]);
    wire wrp_q = irq_dma_mask[timer_irq_pkg::B_WRAPI] && timer_flags[timer_irq_pkg::F_WRAP];
    // group code; capture outranks compare, compare outranks wrap
    timer_irq_pkg::grp_t next_group;
    assign next_group = cap_q ? timer_irq_pkg::GRP_CAPT
                      : cmp_q ? timer_irq_pkg::GRP_CMPR
                      : timer_irq_pkg::GRP_WRAP;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_req      <= 1'b0;
            vector_group <= timer_irq_pkg::GRP_WRAP;
        end
        else
        begin
            irq_req <= gen && (cap_q || cmp_q || wrp_q);
            // one vector, group updated while pending, held otherwise
            if (gen && (cap_q || cmp_q || wrp_q))
                vector_group <= next_group;
        end
    end
    assign irq_vector = {vector_msbs, vector_group, 1'b0};

    // ----------------------------------------------------------------
    // Bus read path.
    // ----------------------------------------------------------------
    wire [7:0] rd_index = s_axi_araddr[9:2];
    wire [7:0] ctl_view = {cpe_view, cme_view, 2'b00, swap_mode_enable, 2'b00,
                           capture_irq_combine};
    wire rd_ok = rd_index == timer_irq_pkg::IDX_CNT_PTR
                 || rd_index == timer_irq_pkg::IDX_ADR_PTR
                 || rd_index == timer_irq_pkg::IDX_VECTOR
                 || rd_index == timer_irq_pkg::IDX_FLAGS
                 || rd_index == timer_irq_pkg::IDX_CTRL
                 || rd_index == timer_irq_pkg::IDX_MASK;
    wire [7:0] rd_byte =
          (rd_index == timer_irq_pkg::IDX_CNT_PTR) ? dma_counter_ptr
        : (rd_index == timer_irq_pkg::IDX_ADR_PTR) ? dma_address_ptr
        : (rd_index == timer_irq_pkg::IDX_VECTOR)  ? irq_vector
        : (rd_index == timer_irq_pkg::IDX_FLAGS)   ? timer_flags
        : (rd_index == timer_irq_pkg::IDX_CTRL)    ? ctl_view
        : (rd_index == timer_irq_pkg::IDX_MASK)    ? irq_dma_mask
        : 8'h00;

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= timer_irq_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte};
            s_axi_rresp  <= rd_ok ? timer_irq_pkg::RESP_OKAY : timer_irq_pkg::RESP_ERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks.
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_flip;
        cmp0_done && swap_now && !(wr_en && hit_cnt);
    endsequence
    sequence s_cap_dma;
        capture0_evt && cp0_dma;
    endsequence
    sequence s_cap_req;
        dma_req_capture0 ##1 (!dma_req_capture0 || capture0_evt);
    endsequence
    gate_off_a: assert property (!gen |=> !irq_req)
        else $error("interrupt passed with global enable low");
    cap0_end_a: assert property (cap0_done |=> !cp0_dma)
        else $error("capture 0 DMA enable not cleared");
    cmp0_end_a: assert property (cmp0_done |=> !cm0_dma)
        else $error("compare 0 DMA enable not cleared");
    wrap_req_a: assert property (gen && wrp_q |=> irq_req)
        else $error("wrap request lost");
    swap_flip_a: assert property (s_flip |=> $changed(dma_counter_ptr[2]))
        else $error("counter pointer bit 2 did not toggle");
    dir_bit_a: assert property (dma_req_compare0 |-> dma_direction_bit)
        else $error("direction bit not one for compare DMA");
    vec_code_a: assert property (irq_vector[2:1] != 2'b01 && !irq_vector[0])
        else $error("illegal vector group code");
    end_forced_a: assert property (!swap_now |-> cpe_view && cme_view)
        else $error("end bits not forced without swap");
    dma_path_a: assert property (s_cap_dma |=> s_cap_req)
        else $error("capture 0 DMA request missing");
endmodule

// file: verilog/timer_irq_pkg.sv
package timer_irq_pkg;

    // ----------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_CNT_PTR = 8'hF0;
    localparam logic [7:0] IDX_ADR_PTR = 8'hF1;
    localparam logic [7:0] IDX_VECTOR  = 8'hF2;
    localparam logic [7:0] IDX_FLAGS   = 8'hF3;
    localparam logic [7:0] IDX_CTRL    = 8'hF4;
    localparam logic [7:0] IDX_MASK    = 8'hFF;

    // ----------------------------------------------------------------
    // Mask register fields.
    // ----------------------------------------------------------------
    localparam int B_GLOBAL   = 7;
    localparam int B_CAP0_DMA = 6;
    localparam int B_CAP0_IRQ = 5;
    localparam int B_CAP1_IRQ = 4;
    localparam int B_CMP0_DMA = 3;
    localparam int B_CMP0_IRQ = 2;
    localparam int B_CMP1_IRQ = 1;
    localparam int B_WRAPI    = 0;

    // ----------------------------------------------------------------
    // Flag, control and pointer fields.
    // ----------------------------------------------------------------
    localparam int F_CP0  = 7;
    localparam int F_CP1  = 6;
    localparam int F_CM0  = 5;
    localparam int F_CM1  = 4;
    localparam int F_WRAP = 3;
    localparam int F_EOB0 = 2;
    localparam int F_EOB1 = 1;
    localparam int C_CPE  = 7;
    localparam int C_CME  = 6;
    localparam int C_SWAP = 3;
    localparam int C_COMB = 0;
    localparam int P_SWAP = 2;
    localparam int P_DIR  = 1;
    localparam int P_SEL  = 0;

    // ----------------------------------------------------------------
    // Reset values and bus responses.
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_MASK  = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [5:0] RST_PTR   = 6'h00;
    localparam logic [4:0] RST_VEC   = 5'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_ERR  = 2'h2;

    typedef enum logic [1:0] {
        GRP_WRAP = 2'b00,
        GRP_CAPT = 2'b10,
        GRP_CMPR = 2'b11
    } grp_t;

endpackage

// file: tb/dma_arbiter_model.sv
// ----------------------------------------------------------------
// Far-side DMA arbiter: ends a block after BLOCK_LEN requests.
// ----------------------------------------------------------------
module dma_arbiter_model #(
    parameter int BLOCK_LEN = 2
) (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Requests from the timer
    input  wire logic dma_req_capture0,
    input  wire logic dma_req_compare0,
    // End-of-block pulses back to the timer
    output logic      capture0_eob,
    output logic      compare0_eob
);
    timeunit 1ns;
    timeprecision 1ps;
    int cap_cnt;
    int cmp_cnt;
    always_ff @(posedge aclk)
    begin
        capture0_eob <= 1'h0;
        compare0_eob <= 1'h0;
        if (!aresetn)
        begin
            cap_cnt <= 0;
            cmp_cnt <= 0;
        end
        else
        begin
            if (dma_req_capture0)
                cap_cnt <= (cap_cnt == BLOCK_LEN - 1) ? 0 : cap_cnt + 1;
            if (dma_req_capture0 && cap_cnt == BLOCK_LEN - 1)
                capture0_eob <= 1'h1;
            if (dma_req_compare0)
                cmp_cnt <= (cmp_cnt == BLOCK_LEN - 1) ? 0 : cmp_cnt + 1;
            if (dma_req_compare0 && cmp_cnt == BLOCK_LEN - 1)
                compare0_eob <= 1'h1;
        end
    end
endmodule

// file: tb/timer_irq_dma_control_tb.sv
module timer_irq_dma_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic        capture0_evt = 1'h0, capture1_evt = 1'h0, compare0_evt = 1'h0;
    logic        compare1_evt = 1'h0, wrap_evt = 1'h0, capture0_eob, compare0_eob;
    logic        irq_req, dma_req_capture0, dma_req_compare0, dma_use_regfile;
    logic        dma_use_seg_dma, dma_use_address_ptr, dma_table_select;
    logic [7:0]  irq_vector, dma_counter_ptr, dma_address_ptr;
    int          miscompares = 0;
    int          total_checks = 0;

    always #5 aclk = ~aclk;

    timer_irq_dma_control timer_irq_dma_control_i (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .capture0_evt, .capture1_evt, .compare0_evt, .compare1_evt,
        .wrap_evt, .capture0_eob, .compare0_eob, .irq_req, .irq_vector,
        .dma_req_capture0, .dma_req_compare0, .dma_counter_ptr, .dma_address_ptr,
        .dma_use_regfile, .dma_use_seg_dma, .dma_use_address_ptr, .dma_table_select);

    dma_arbiter_model dma_arbiter_model_i (.aclk, .aresetn, .dma_req_capture0,
        .dma_req_compare0, .capture0_eob, .compare0_eob);

    // ----------------------------------------------------------------
    // Bus and check tasks
    // ----------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Ready is read at the falling edge, which shows what the next rising edge samples.
    task wr(input logic [7:0] idx, input logic [7:0] d);
        logic aw, w, b;
        @(posedge aclk);
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        b = 1'h0;
        while (!b)
        begin
            @(negedge aclk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bready & s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
            if (b) s_axi_bready <= 1'h0;
        end
    endtask

    task rdr(input logic [7:0] idx);
        logic ar, r;
        @(posedge aclk);
        s_axi_araddr <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        r = 1'h0;
        while (!r)
        begin
            @(negedge aclk);
            ar = s_axi_arvalid & s_axi_arready;
            r = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'h0;
            if (r) s_axi_rready <= 1'h0;
        end
    endtask

    task settle;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
    endtask

    task pulse(input logic [4:0] e);
        @(posedge aclk);
        {capture0_evt, capture1_evt, compare0_evt, compare1_evt, wrap_evt} <= e;
        @(posedge aclk);
        {capture0_evt, capture1_evt, compare0_evt, compare1_evt, wrap_evt} <= 5'h00;
        repeat (3) @(posedge aclk);
        settle;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_map;
        rdr(8'hFF);
        chk(rd, 32'h00);
        rdr(8'hF4);
        chk(rd, 32'hC0);
        wr(8'hF2, 8'hFF);
        rdr(8'hF2);
        chk(rd, 32'hF8);
        wr(8'hF5, 8'hFF);
        chk(resp, 2'h2);
        rdr(8'hF5);
        chk(resp, 2'h2);
        chk(rd, 32'h00);
    endtask

    task t_wrap;
        wr(8'hFF, 8'h01);
        pulse(5'h01);
        chk(irq_req, 1'h0);
        wr(8'hFF, 8'h81);
        settle;
        chk(irq_req, 1'h1);
        chk(irq_vector, 8'hF8);
        wr(8'hFF, 8'h80);
        settle;
        chk(irq_req, 1'h0);
        wr(8'hF3, 8'h08);
    endtask

    task t_groups;
        wr(8'hFF, 8'hB0);
        wr(8'hF4, 8'h01);
        pulse(5'h10);
        chk(irq_req, 1'h0);
        pulse(5'h08);
        chk({irq_req, irq_vector}, 9'h1FC);
        wr(8'hF3, 8'hC0);
        wr(8'hFF, 8'h82);
        pulse(5'h02);
        chk({irq_req, irq_vector}, 9'h1FE);
        wr(8'hF3, 8'h10);
    endtask

    task t_area;
        wr(8'hF0, 8'h01);
        settle;
        chk({dma_use_regfile, dma_use_address_ptr}, 2'h2);
        wr(8'hF0, 8'h00);
        wr(8'hF1, 8'h01);
        settle;
        chk({dma_use_seg_dma, dma_use_address_ptr}, 2'h3);
    endtask

    task t_dma;
        wr(8'hF4, 8'h08);
        wr(8'hFF, 8'h8C);
        pulse(5'h04);
        pulse(5'h04);
        rdr(8'hFF);
        chk(rd, 32'h84);
        rdr(8'hF3);
        chk(rd, 32'h02);
        chk({irq_req, irq_vector}, 9'h1FE);
        chk({dma_counter_ptr, dma_address_ptr}, 16'h0607);
        chk(dma_table_select, 1'h1);
        rdr(8'hF4);
        chk(rd, 32'h48);
        wr(8'hF3, 8'h02);
        wr(8'hF4, 8'h00);
        wr(8'hFF, 8'hE0);
        pulse(5'h10);
        pulse(5'h10);
        rdr(8'hFF);
        chk(rd, 32'hA0);
        chk({irq_req, dma_counter_ptr}, 9'h104);
        chk(irq_vector, 8'hFC);
    endtask

    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        end_of_test;
    end

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        t_map;
        t_wrap;
        t_groups;
        t_area;
        t_dma;
        end_of_test;
    end
endmodule
